// ### hdl/rst_seq_pkg.sv
/*
  constants for the dual rail reset sequencer: timeout, clock rate, output stage choice.
  assumes a single 20 MHz clock drives all users.
*/
package rst_seq_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TIMEOUT_MS = 10;
  // 10 ms at 20 MHz, a least time, clamped to at least one cycle
  localparam int unsigned TIMEOUT_CYCLES = (TIMEOUT_MS * (CLK_HZ / 1000) + 0) < 1 ? 1 :
    TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic STAGE_PUSH_PULL = 1'b0;
  localparam logic STAGE_OPEN_DRAIN = 1'b1;
  localparam logic RESET_ASSERTED = 1'b0;
  localparam logic RESET_RELEASED = 1'b1;
endpackage

// ### hdl/rail_channel.sv
/*
  one reset channel: holds reset low while the rail is out of window,
  releases after a full timeout of in-window time.
  assumes sense is synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rail_channel
  import rst_seq_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYCLES,
  parameter int unsigned W = CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hold,
  input wire logic sense,
  output logic reset_n
);
  localparam logic [W-1:0] CNT_ZERO = '0;
  localparam logic [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] CNT_END = W'(TIMEOUT - 1);

  logic [W-1:0] cnt_r;
  logic released_r;

  // =====================================
  // timeout counter
  // restart from zero on any excursion, so a flickering rail never releases early
  // an excursion restarts the count even with ce low, else a frozen channel would release at once on return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= CNT_ZERO;
    end else if (!sense) begin
      cnt_r <= CNT_ZERO;
    end else if (ce) begin
      if (hold) begin
        cnt_r <= CNT_ZERO;
      end else if (!released_r && cnt_r != CNT_END) begin
        cnt_r <= cnt_r + CNT_ONE;
      end
    end
  end

  // =====================================
  // release state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      released_r <= 1'b0;
    end else if (!sense) begin
      released_r <= 1'b0;
    end else if (ce) begin
      if (hold) begin
        released_r <= 1'b0;
      end else if (cnt_r == CNT_END) begin
        released_r <= 1'b1;
      end
    end
  end

  // combinational low path: an out-of-window rail asserts reset with no clock delay
  assign reset_n = (sense && released_r && !hold) ? RESET_RELEASED : RESET_ASSERTED;

  // =====================================
  // checks
  property p_fast_assert;
    @(posedge clk) disable iff (!rst_n) !sense |-> !reset_n;
  endproperty
  a_fast_assert: assert property (p_fast_assert) else $error("reset not low with rail out");

  property p_no_early_release;
    @(posedge clk) disable iff (!rst_n) $rose(reset_n) |-> $past(sense) && $past(cnt_r) == CNT_END;
  endproperty
  a_no_early_release: assert property (p_no_early_release) else $error("release before timeout");

  property p_restart;
    @(posedge clk) disable iff (!rst_n) (ce && !sense) |=> cnt_r == CNT_ZERO;
  endproperty
  a_restart: assert property (p_restart) else $error("counter did not restart");

  property p_release_done;
    @(posedge clk) disable iff (!rst_n) (ce && sense && !hold && cnt_r == CNT_END) ##1 (sense && !hold)
      |-> reset_n;
  endproperty
  a_release_done: assert property (p_release_done) else $error("no release after timeout");
endmodule // rail_channel
`default_nettype wire

// ### hdl/dual_rail_reset_timeout.sv
/*
  dual rail reset generator behind a window supervisor: two independent channels,
  power-up hold, open-drain or push-pull output stage.
  assumes rst_n is the supply lockout release, synchronous to the free running clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dual_rail_reset_timeout
  import rst_seq_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYCLES, // 10 ms default
  parameter logic OUT_STAGE = STAGE_PUSH_PULL
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rail_one_sense,
  input wire logic rail_two_sense,
  output logic rail_one_reset_n_o,
  output logic rail_one_reset_n_oe,
  output logic rail_two_reset_n_o,
  output logic rail_two_reset_n_oe,
  output logic supply_lockout_hold
);
  localparam int unsigned W = $clog2(TIMEOUT + 1);
  localparam logic [W-1:0] CNT_ZERO = '0;
  localparam logic [W-1:0] CNT_ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] CNT_END = W'(TIMEOUT - 1);

  typedef enum logic [0:0] {
    ST_POWERUP = 1'b0,
    ST_RUN = 1'b1
  } pu_state_t;

  pu_state_t state_r;
  logic [W-1:0] pu_cnt_r;
  logic hold;
  logic one_n;
  logic two_n;

  // =====================================
  // power-up hold after lockout release
  // the hold only forces reset; each channel still times its own rail during the hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_POWERUP;
      pu_cnt_r <= CNT_ZERO;
    end else if (ce) begin
      case (state_r)
        ST_POWERUP: begin
          if (pu_cnt_r == CNT_END) begin
            state_r <= ST_RUN;
          end else begin
            pu_cnt_r <= pu_cnt_r + CNT_ONE;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  assign hold = (state_r == ST_POWERUP);
  assign supply_lockout_hold = hold;

  // =====================================
  // channels, one instance per rail with no shared state
  rail_channel #(.TIMEOUT(TIMEOUT), .W(W)) u_one (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .hold(1'b0),
    .sense(rail_one_sense),
    .reset_n(one_n)
  );

  rail_channel #(.TIMEOUT(TIMEOUT), .W(W)) u_two (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .hold(1'b0),
    .sense(rail_two_sense),
    .reset_n(two_n)
  );

  // =====================================
  // output stage
  // channels run through the power-up window too, so a rail already good releases
  // exactly when the hold ends: the two timeouts coincide, both 10 ms
  logic one_final;
  logic two_final;
  assign one_final = one_n & ~hold;
  assign two_final = two_n & ~hold;

  // open drain: drive low only, release otherwise; push-pull drives always
  // the high level of an open-drain pin comes from the board pull-up, so it rises slowly
  function automatic logic stage_o(input logic level);
    if (OUT_STAGE == STAGE_OPEN_DRAIN) begin
      stage_o = RESET_ASSERTED;
    end else begin
      stage_o = level;
    end
  endfunction

  function automatic logic stage_oe(input logic level);
    if (OUT_STAGE == STAGE_OPEN_DRAIN) begin
      stage_oe = ~level;
    end else begin
      stage_oe = 1'b1;
    end
  endfunction

  assign rail_one_reset_n_o = stage_o(one_final);
  assign rail_one_reset_n_oe = stage_oe(one_final);
  assign rail_two_reset_n_o = stage_o(two_final);
  assign rail_two_reset_n_oe = stage_oe(two_final);

  // =====================================
  // checks
  property p_pu_hold;
    @(posedge clk) disable iff (!rst_n) hold |-> !one_final && !two_final;
  endproperty
  a_pu_hold: assert property (p_pu_hold) else $error("reset released during power-up hold");

  property p_one_own;
    @(posedge clk) disable iff (!rst_n) !rail_one_sense |-> !one_final;
  endproperty
  a_one_own: assert property (p_one_own) else $error("rail one out but reset one high");

  property p_two_own;
    @(posedge clk) disable iff (!rst_n) !rail_two_sense |-> !two_final;
  endproperty
  a_two_own: assert property (p_two_own) else $error("rail two out but reset two high");

  property p_od_low;
    @(posedge clk) disable iff (!rst_n) (OUT_STAGE == STAGE_OPEN_DRAIN) |->
      !rail_one_reset_n_o && !rail_two_reset_n_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain stage drives high");

  // =====================================
  // hold and pin level checks, valid for either output stage

  property p_rst_hold;
    @(posedge clk) !rst_n |=> hold;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("lockout did not start the hold");

  property p_hold_len;
    @(posedge clk) disable iff (!rst_n) $fell(hold) |-> $past(pu_cnt_r) == CNT_END;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold ended early");

  property p_hold_run;
    @(posedge clk) disable iff (!rst_n) (hold && pu_cnt_r != CNT_END) |=> hold;
  endproperty
  a_hold_run: assert property (p_hold_run) else $error("hold dropped before count end");

  property p_hold_ends;
    @(posedge clk) disable iff (!rst_n) (ce && hold && pu_cnt_r == CNT_END) |=> !hold;
  endproperty
  a_hold_ends: assert property (p_hold_ends) else $error("hold did not end");

  property p_pins_hold;
    @(posedge clk) disable iff (!rst_n) hold |->
      rail_one_reset_n_oe && !rail_one_reset_n_o && rail_two_reset_n_oe && !rail_two_reset_n_o;
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pin not driven low during hold");

  property p_one_rise;
    @(posedge clk) disable iff (!rst_n) $rose(one_final) |-> $past(rail_one_sense) && rail_one_sense;
  endproperty
  a_one_rise: assert property (p_one_rise) else $error("reset one released with rail one out");

  property p_two_rise;
    @(posedge clk) disable iff (!rst_n) $rose(two_final) |-> $past(rail_two_sense) && rail_two_sense;
  endproperty
  a_two_rise: assert property (p_two_rise) else $error("reset two released with rail two out");

  property p_one_pin_low;
    @(posedge clk) disable iff (!rst_n) !rail_one_sense |-> rail_one_reset_n_oe && !rail_one_reset_n_o;
  endproperty
  a_one_pin_low: assert property (p_one_pin_low) else $error("pin one not low with rail out");

  property p_two_pin_low;
    @(posedge clk) disable iff (!rst_n) !rail_two_sense |-> rail_two_reset_n_oe && !rail_two_reset_n_o;
  endproperty
  a_two_pin_low: assert property (p_two_pin_low) else $error("pin two not low with rail out");

  property p_pp_drive;
    @(posedge clk) disable iff (!rst_n) (OUT_STAGE == STAGE_PUSH_PULL) |->
      rail_one_reset_n_oe && rail_two_reset_n_oe;
  endproperty
  a_pp_drive: assert property (p_pp_drive) else $error("push-pull stage not driving");

  property p_od_release;
    @(posedge clk) disable iff (!rst_n) (OUT_STAGE == STAGE_OPEN_DRAIN && one_final && two_final) |->
      !rail_one_reset_n_oe && !rail_two_reset_n_oe;
  endproperty
  a_od_release: assert property (p_od_release) else $error("open drain pin not released");
endmodule // dual_rail_reset_timeout
`default_nettype wire

// ### testbench/rail_supply_model.sv
/*
  model of the far side: the two monitored rails and the pull-ups on the reset pins.
  assumes the bench sets the wanted rail state on the clock's rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rail_supply_model (
  input wire logic want_one,
  input wire logic want_two,
  input wire logic reset_one_o,
  input wire logic reset_one_oe,
  input wire logic reset_two_o,
  input wire logic reset_two_oe,
  output logic rail_one_sense,
  output logic rail_two_sense,
  output logic pin_one,
  output logic pin_two
);
  // ==========================================
  // rails and pins
  assign rail_one_sense = want_one;
  assign rail_two_sense = want_two;
  // released pins float up through the pull-up, never keep the last driven level
  assign pin_one = reset_one_oe ? reset_one_o : 1'b1;
  assign pin_two = reset_two_oe ? reset_two_o : 1'b1;
endmodule // rail_supply_model
`default_nettype wire

// ### testbench/dual_rail_reset_timeout_tb_top.sv
/*
  self-checking bench for the dual rail reset generator, open-drain build, short timeout.
  assumes rst_seq_pkg is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module dual_rail_reset_timeout_tb_top;
  import rst_seq_pkg::*;
  // ==========================================
  // setup
  // small timeout keeps the run short; all expectations but the package timeout check derive from it
  localparam int unsigned T = 8;
  typedef struct {logic r, s1, s2; int n; logic e1, e2, eh;} row_t;
  logic clk = 0, rst_n = 0, ce = 1, want_one = 1, want_two = 1;
  logic s1, s2, o1, oe1, o2, oe2, hold, pin1, pin2;
  int n_errors = 0, n_checks = 0;
  row_t rows [13] = '{'{1,1,1,T-1,0,0,1}, '{1,1,1,0,1,1,0},
    '{1,0,1,0,0,1,0}, '{1,1,1,T-1,0,1,0}, '{1,1,1,0,1,1,0},
    '{1,1,0,0,1,0,0}, '{1,1,1,T-3,1,0,0}, '{1,1,0,0,1,0,0},
    '{1,1,1,T-1,1,0,0}, '{1,1,1,0,1,1,0},
    '{0,1,1,1,0,0,1}, '{1,1,1,T-1,0,0,1}, '{1,1,1,0,1,1,0}};
  always #25 clk = ~clk;
  dual_rail_reset_timeout #(.TIMEOUT(T), .OUT_STAGE(STAGE_OPEN_DRAIN)) i_dual_rail_reset_timeout (
    .clk(clk), .rst_n(rst_n), .ce(ce), .rail_one_sense(s1), .rail_two_sense(s2),
    .rail_one_reset_n_o(o1), .rail_one_reset_n_oe(oe1), .rail_two_reset_n_o(o2),
    .rail_two_reset_n_oe(oe2), .supply_lockout_hold(hold));
  rail_supply_model i_rail_supply_model (
    .want_one(want_one), .want_two(want_two), .reset_one_o(o1), .reset_one_oe(oe1),
    .reset_two_o(o2), .reset_two_oe(oe2), .rail_one_sense(s1), .rail_two_sense(s2),
    .pin_one(pin1), .pin_two(pin2));
  // ==========================================
  // checking
  task automatic check(input string name, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // sequence: rows hold power-up, excursions, restart and a mid-run lockout
  initial begin
    repeat (3) @(posedge clk);
    check("timeout cycles", 1'(TIMEOUT_CYCLES == 200_000), 1'b1);
    foreach (rows[i]) begin
      @(posedge clk);
      rst_n <= rows[i].r;
      want_one <= rows[i].s1;
      want_two <= rows[i].s2;
      repeat (rows[i].n) @(posedge clk);
      #1;
      check("pin one", pin1, rows[i].e1);
      check("pin two", pin2, rows[i].e2);
      if (rows[i].eh !== 1'bx) check("lockout hold", hold, rows[i].eh);
      $display("row %0d done", i);
    end
    // clock enable low: excursion still asserts and still restarts the timeout
    @(posedge clk);
    ce <= 0;
    want_one <= 0;
    @(posedge clk);
    #1;
    check("pin one ce low", pin1, 1'b0);
    @(posedge clk);
    want_one <= 1;
    repeat (T + 2) @(posedge clk);
    #1;
    check("pin one frozen", pin1, 1'b0);
    check("pin two frozen", pin2, 1'b1);
    @(posedge clk);
    ce <= 1;
    repeat (T - 1) @(posedge clk);
    #1;
    check("pin one before end", pin1, 1'b0);
    @(posedge clk);
    #1;
    check("pin one after end", pin1, 1'b1);
    $display("clock enable test done");
    tally_and_finish();
  end
endmodule // dual_rail_reset_timeout_tb_top
`default_nettype wire
